// ===== rtl/dtc_ahb_regs.sv
// AHB-Lite slave holding the configuration register and the status view.
`timescale 1ns/1ps
module dtc_ahb_regs (
  // Clock and reset.
  input  wire logic                   clk_in,
  input  wire logic                   resetn_in,
  input  wire logic                   ce_in,
  // Bus.
  input  wire dtc_pkg::dtc_ahb_s      ahb_in,
  output logic                        hreadyout_out,
  output logic                        hresp_out,
  output logic [31:0]                 hrdata_out,
  // Core side.
  input  wire logic [dtc_pkg::STAT_W-1:0] status_in,
  output dtc_pkg::dtc_cfg_s           cfg_out
);
  import dtc_pkg::*;

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_addr;
    dtc_cfg_s    cfg;
    logic [31:0] rdata;
    logic        ready;
  } dtc_bus_s;

  dtc_bus_s bus_reg;
  dtc_bus_s bus_next;
  logic     take;

  assign take = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;

  always_comb begin
    bus_next = bus_reg;
    if (ce_in) begin
      bus_next.wr_pend = 1'b0;
      if (bus_reg.wr_pend && bus_reg.wr_addr == CFG_OFS) begin
        bus_next.cfg = dtc_cfg_s'(ahb_in.hwdata[CFG_W-1:0]);
      end
      if (take) begin
        bus_next.wr_pend = ahb_in.hwrite;
        bus_next.wr_addr = ahb_in.haddr[7:0];
        bus_next.rdata   = 32'h0000_0000;
        if (!ahb_in.hwrite && ahb_in.haddr[7:0] == CFG_OFS) begin
          bus_next.rdata[CFG_W-1:0] = bus_next.cfg;
        end else if (!ahb_in.hwrite && ahb_in.haddr[7:0] == STAT_OFS) begin
          bus_next.rdata[STAT_W-1:0] = status_in;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_reg       <= '0;
      bus_reg.ready <= 1'b1;
      bus_reg.cfg   <= '{al: AL_RST, cwl: CWL_RST, default: '0};
    end else begin
      bus_reg <= bus_next;
    end
  end

  assign hreadyout_out = bus_reg.ready;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = bus_reg.rdata;
  assign cfg_out       = bus_reg.cfg;

endmodule : dtc_ahb_regs

// ===== rtl/dtc_odt_delay.sv
// Shift register that delays the sampled ODT pin by a selectable latency.
`timescale 1ns/1ps
module dtc_odt_delay (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       ce_in,
  // Pin sample and tap.
  input  wire logic       odt_in,
  input  wire logic [4:0] tap_in,
  output logic            odt_dly_out
);
  import dtc_pkg::*;

  typedef struct packed {
    logic [DLY_DEPTH-1:0] sh;
  } dtc_dly_s;

  dtc_dly_s dly_reg;
  dtc_dly_s dly_next;

  always_comb begin
    dly_next = dly_reg;
    if (ce_in) begin
      dly_next.sh = {dly_reg.sh[DLY_DEPTH-2:0], odt_in};
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dly_reg <= '0;
    end else begin
      dly_reg <= dly_next;
    end
  end

  assign odt_dly_out = dly_reg.sh[tap_in];

endmodule : dtc_odt_delay

// ===== rtl/dtc_pkg.sv
// Shared constants, types and register layout of the termination control block.
package dtc_pkg;

  // ==========================================================================
  // Timing.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TRFC_PS       = 160000;
  localparam int TAONPD_MIN_PS = 2000;
  localparam int TAONPD_MAX_PS = 8500;
  localparam int TRFC_CYC      = (TRFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ASYNC_MIN_CYC = (TAONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ASYNC_MAX_CYC = TAONPD_MAX_PS / CLK_PERIOD_PS;
  localparam int TCPDED_CYC    = 2;
  localparam int CWN4_BASE     = 4;
  localparam int CWN8_BASE     = 6;
  localparam int LAT_BIAS      = 2;
  localparam int DLY_DEPTH     = 32;

  // ==========================================================================
  // Register map and reset values.
  localparam logic [7:0]  CFG_OFS    = 8'h00;
  localparam logic [7:0]  STAT_OFS   = 8'h04;
  localparam int          CFG_W      = 15;
  localparam logic [3:0]  CWL_RST    = 4'h5;
  localparam logic [4:0]  AL_RST     = 5'h00;
  localparam int          ST_RTT_ON  = 0;
  localparam int          ST_WR_SEL  = 1;
  localparam int          ST_ASYNC_B = 2;
  localparam int          ST_TRANS_B = 3;
  localparam int          ST_PD_B    = 4;
  localparam int          STAT_W     = 5;

  // ==========================================================================
  // Types. The configuration struct is the register layout, MSB first.
  typedef enum logic [1:0] {MODE_SYNC, MODE_TRANS, MODE_ASYNC} dtc_mode_e;

  typedef struct packed {
    logic [4:0] al;
    logic [3:0] cwl;
    logic       dll_pd_on;
    logic [1:0] rtt_wr;
    logic [2:0] rtt_nom;
  } dtc_cfg_s;

  typedef struct packed {
    logic write;
    logic bc4;
    logic refresh;
    logic banks_idle;
    logic rd_drive;
  } dtc_cmd_s;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } dtc_ahb_s;

endpackage : dtc_pkg

// ===== rtl/dtc_top.sv
// Termination control core: latency pipeline, write strength and power-down modes.
`timescale 1ns/1ps
// ============================================================================
// Contract
// - Termination stays off while device drives data.
// - Dynamic switching on when either write bit set.
// - Nominal from MR1 bits, write from MR2.
// - Without writes, nominal strength follows delayed ODT.
// - Write strength selected WL-2 after write.
// - Nominal returns 4 or 6 plus turn-off latency.
// - Termination on and off WL-2 after ODT.
// - Asynchronous mode in precharge power-down, DLL frozen.
// - Asynchronous mode ignores additive latency.
// - Asynchronous response within 2 to 8.5 ns.
// - ODT stays active; no commands in power-down.
// - Transition period from CKE low to entry delay.
// - Refresh in progress extends the transition period.
// - Transition response may be synchronous or asynchronous.
// - Synchronous latency equals CWL plus AL minus two.
// - ODT low or all bits zero means off.
module dtc_top (
  // Clock, reset and enable.
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              ce_in,
  // Register bus.
  input  wire dtc_pkg::dtc_ahb_s ahb_in,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  output logic [31:0]            hrdata_out,
  // Device pins and command decode.
  input  wire logic              odt_in,
  input  wire logic              cke_in,
  input  wire dtc_pkg::dtc_cmd_s cmd_in,
  // Termination control.
  output logic                   rtt_on_out,
  output logic                   rtt_wr_sel_out,
  output logic [2:0]             rtt_val_out,
  output logic                   async_mode_out,
  output logic                   transition_out
);
  import dtc_pkg::*;

  // ==========================================================================
  // State.
  typedef struct packed {
    dtc_mode_e  mode;
    logic       cke_prev;
    logic [5:0] trans_cnt;
    logic [5:0] ref_cnt;
    logic       wr_busy;
    logic       wr_bc4;
    logic [5:0] wr_cnt;
    logic       rtt_on;
    logic       rtt_wr_sel;
    logic [2:0] rtt_val;
    logic       async_mode;
    logic       transition;
  } dtc_core_s;

  dtc_core_s core_reg;
  dtc_core_s core_next;

  dtc_cfg_s          cfg;
  logic [4:0]        lat;
  logic [5:0]        revert;
  logic              mode_en;
  logic              dyn_en;
  logic              wr_ev;
  logic              pd_entry;
  logic              odt_dly;
  logic              odt_eff;
  logic              wr_sel_nx;
  logic [STAT_W-1:0] status;

  // ==========================================================================
  // Latency arithmetic.
  function automatic logic [4:0] odt_lat(input logic [3:0] cwl, input logic [4:0] al);
    logic [5:0] sum;
    sum = {2'b00, cwl} + {1'b0, al};
    if (sum <= 6'(LAT_BIAS)) begin
      odt_lat = 5'h01;
    end else if (sum - 6'(LAT_BIAS) >= 6'(DLY_DEPTH)) begin
      odt_lat = 5'(DLY_DEPTH - 1);
    end else begin
      odt_lat = 5'(sum - 6'(LAT_BIAS));
    end
  endfunction : odt_lat

  assign lat      = odt_lat(cfg.cwl, cfg.al);
  assign revert   = 6'(lat) + (core_reg.wr_bc4 ? 6'(CWN4_BASE) : 6'(CWN8_BASE));
  assign mode_en  = (cfg.rtt_nom != 3'h0) || (cfg.rtt_wr != 2'h0);
  assign dyn_en   = cfg.rtt_wr[0] || cfg.rtt_wr[1];
  assign wr_ev    = cmd_in.write && cke_in;
  assign pd_entry = core_reg.cke_prev && !cke_in && cmd_in.banks_idle && !cfg.dll_pd_on;

  // ==========================================================================
  // Register slave and ODT pipeline.
  dtc_ahb_regs u_regs (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .ce_in         (ce_in),
    .ahb_in        (ahb_in),
    .hreadyout_out (hreadyout_out),
    .hresp_out     (hresp_out),
    .hrdata_out    (hrdata_out),
    .status_in     (status),
    .cfg_out       (cfg)
  );

  dtc_odt_delay u_dly (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .ce_in       (ce_in),
    .odt_in      (odt_in),
    .tap_in      (lat - 5'h01),
    .odt_dly_out (odt_dly)
  );

  assign status[ST_RTT_ON]  = core_reg.rtt_on;
  assign status[ST_WR_SEL]  = core_reg.rtt_wr_sel;
  assign status[ST_ASYNC_B] = core_reg.async_mode;
  assign status[ST_TRANS_B] = core_reg.transition;
  assign status[ST_PD_B]    = !core_reg.cke_prev;

  // ==========================================================================
  // Termination path selection.
  always_comb begin
    if (core_reg.mode == MODE_ASYNC) begin
      odt_eff = odt_in;
    end else begin
      odt_eff = odt_dly;
    end
    wr_sel_nx = dyn_en && core_reg.wr_busy
             && (core_reg.wr_cnt >= 6'(lat - 5'h01) || core_reg.rtt_wr_sel)
             && (core_reg.wr_cnt < revert - 6'h01);
  end

  // ==========================================================================
  // Core next state.
  always_comb begin
    core_next = core_reg;
    if (ce_in) begin
      core_next.cke_prev = cke_in;
      if (cmd_in.refresh && cke_in) begin
        core_next.ref_cnt = 6'(TRFC_CYC);
      end else if (core_reg.ref_cnt != 6'h00) begin
        core_next.ref_cnt = core_reg.ref_cnt - 6'h01;
      end
      unique case (core_reg.mode)
        MODE_SYNC: begin
          if (pd_entry) begin
            core_next.mode      = MODE_TRANS;
            core_next.trans_cnt = 6'(TCPDED_CYC);
          end
        end
        MODE_TRANS: begin
          if (core_reg.trans_cnt != 6'h00) begin
            core_next.trans_cnt = core_reg.trans_cnt - 6'h01;
          end
          if (cke_in) begin
            core_next.mode = MODE_SYNC;
          end else if (core_reg.trans_cnt == 6'h00 && core_reg.ref_cnt == 6'h00) begin
            core_next.mode = MODE_ASYNC;
          end
        end
        MODE_ASYNC: begin
          if (cke_in) begin
            core_next.mode = MODE_SYNC;
          end
        end
        default: begin
          core_next.mode = MODE_SYNC;
        end
      endcase
      if (wr_ev) begin
        core_next.wr_busy = 1'b1;
        core_next.wr_cnt  = 6'h00;
        core_next.wr_bc4  = cmd_in.bc4;
      end else if (core_reg.wr_busy) begin
        if (core_reg.wr_cnt >= revert - 6'h01) begin
          core_next.wr_busy = 1'b0;
        end else begin
          core_next.wr_cnt = core_reg.wr_cnt + 6'h01;
        end
      end
      core_next.rtt_wr_sel = wr_sel_nx;
      core_next.rtt_val    = wr_sel_nx ? {1'b0, cfg.rtt_wr} : cfg.rtt_nom;
      core_next.rtt_on     = odt_eff && mode_en && !cmd_in.rd_drive;
      core_next.async_mode = (core_next.mode == MODE_ASYNC);
      core_next.transition = (core_next.mode == MODE_TRANS);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      core_reg          <= '0;
      core_reg.mode     <= MODE_SYNC;
      core_reg.cke_prev <= 1'b1;
    end else begin
      core_reg <= core_next;
    end
  end

  assign rtt_on_out     = core_reg.rtt_on;
  assign rtt_wr_sel_out = core_reg.rtt_wr_sel;
  assign rtt_val_out    = core_reg.rtt_val;
  assign async_mode_out = core_reg.async_mode;
  assign transition_out = core_reg.transition;

  // ==========================================================================
  // Checks.
  logic sync3;
  assign sync3 = ce_in && core_reg.mode == MODE_SYNC && lat == 5'h03 && mode_en
              && !cmd_in.rd_drive && !pd_entry;

  sequence odt_rise3_q;
    (sync3 && odt_in) ##1 sync3 [*3];
  endsequence

  sequence odt_fall3_q;
    (sync3 && !odt_in) ##1 sync3 [*3];
  endsequence

  sequence wr8_q;
    (ce_in && wr_ev && !cmd_in.bc4 && dyn_en && lat == 5'h03 && !core_reg.wr_busy)
      ##1 (ce_in && !wr_ev && dyn_en && lat == 5'h03) [*8];
  endsequence

  odt_on_lat_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    odt_rise3_q |=> rtt_on_out)
    else $error("Termination not on three cycles after ODT high.");

  odt_off_lat_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    odt_fall3_q |=> !rtt_on_out)
    else $error("Termination not off three cycles after ODT low.");

  odt_disabled_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && !mode_en) |=> !rtt_on_out)
    else $error("Termination on while all select bits are zero.");

  read_drive_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && cmd_in.rd_drive) |=> !rtt_on_out)
    else $error("Termination on while the device drives data.");

  async_follow_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && core_reg.mode == MODE_ASYNC && mode_en && !cmd_in.rd_drive)
      |=> (rtt_on_out == $past(odt_in)))
    else $error("Asynchronous termination did not follow ODT in one cycle.");

  wr_select_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && wr_ev && dyn_en && lat == 5'h03 && !core_reg.wr_busy)
      ##1 (ce_in && !wr_ev && dyn_en && lat == 5'h03) [*3]
      |=> rtt_wr_sel_out)
    else $error("Write strength not selected three cycles after write.");

  wr_revert_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr8_q ##1 (ce_in && !wr_ev) |=> !rtt_wr_sel_out)
    else $error("Write strength not released nine cycles after write.");

  no_dyn_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && !dyn_en) |=> !rtt_wr_sel_out)
    else $error("Write strength selected with dynamic switching off.");

  trans_entry_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && core_reg.mode == MODE_SYNC && pd_entry) |=> transition_out [*2])
    else $error("Transition period not entered on CKE low.");

  async_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(async_mode_out) |-> (!$past(cfg.dll_pd_on) && !$past(cke_in)))
    else $error("Asynchronous mode entered without frozen DLL power-down.");

  refresh_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ce_in && core_reg.ref_cnt > 6'h01 && core_reg.mode == MODE_TRANS) |=> !async_mode_out)
    else $error("Transition ended while a refresh was in progress.");

endmodule : dtc_top

// ===== tb/dtc_ctrl_model.sv
// Behavioural memory controller driving the termination, power-down and command pins.
`timescale 1ns/1ps
module dtc_ctrl_model (
  // Clock.
  input  wire logic         clk_in,
  // Pins towards the device.
  output logic              odt_out,
  output logic              cke_out,
  output dtc_pkg::dtc_cmd_s cmd_out
);
  import dtc_pkg::*;
  localparam int ODTH4 = 4;
  localparam int ODTH8 = 6;
  int cyc;
  int odt_free;

  initial begin
    odt_out = 1'b0;
    cke_out = 1'b1;
    cmd_out = '0;
    cmd_out.banks_idle = 1'b1;
    cyc = 0;
    odt_free = 0;
  end

  always @(posedge clk_in) cyc <= cyc + 1;

  // ==========================================================================
  // Pin tasks; each returns at the edge where the device samples the change.
  task automatic set_odt(input logic v);
    @(posedge clk_in);
    while (!v && cyc < odt_free) @(posedge clk_in);
    if (v && !odt_out) odt_free = cyc + ODTH4;
    odt_out <= v;
    @(posedge clk_in);
  endtask : set_odt

  task automatic pulse_cmd(input logic wr, input logic bc4);
    int h;
    h = bc4 ? ODTH4 : ODTH8;
    @(posedge clk_in);
    if (cke_out) begin
      cmd_out.write <= wr;
      cmd_out.refresh <= !wr;
      cmd_out.bc4 <= bc4;
      if (wr && odt_out && odt_free < cyc + h) odt_free = cyc + h;
    end
    @(posedge clk_in);
    cmd_out.write <= 1'b0;
    cmd_out.refresh <= 1'b0;
  endtask : pulse_cmd

  task automatic set_idle(input logic v);
    @(posedge clk_in);
    cmd_out.banks_idle <= v;
    @(posedge clk_in);
  endtask : set_idle

  task automatic set_cke(input logic v);
    @(posedge clk_in);
    cke_out <= v;
    @(posedge clk_in);
  endtask : set_cke

  task automatic set_dq(input logic v);
    @(posedge clk_in);
    while (v && odt_out) @(posedge clk_in);
    cmd_out.rd_drive <= v;
    @(posedge clk_in);
  endtask : set_dq
endmodule : dtc_ctrl_model

// ===== tb/dtc_top_tb.sv
// Self-checking bench for the termination control block.
`timescale 1ns/1ps
module dtc_top_tb;
  import dtc_pkg::*;
  logic        clk_in;
  logic        resetn_in;
  logic        ce;
  logic        odt;
  logic        cke;
  logic        hready;
  logic        hresp;
  logic        rtt_on;
  logic        wr_sel;
  logic        async_m;
  logic        trans;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [2:0]  rtt_val;
  dtc_cmd_s    cmd;
  dtc_ahb_s    ahb_m;
  dtc_ahb_s    ahb_w;
  int          fails;
  int          compares;

  always_comb begin
    ahb_w = ahb_m;
    ahb_w.hready = hready;
  end

  dtc_top i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce), .ahb_in(ahb_w),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .odt_in(odt),
    .cke_in(cke), .cmd_in(cmd), .rtt_on_out(rtt_on), .rtt_wr_sel_out(wr_sel),
    .rtt_val_out(rtt_val), .async_mode_out(async_m), .transition_out(trans));
  dtc_ctrl_model i_ctrl (.clk_in(clk_in), .odt_out(odt), .cke_out(cke), .cmd_out(cmd));

  // ==========================================================================
  // Common tasks.
  task automatic finish_test();
    $display("Compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      fails++;
      finish_test();
    end
  endtask : wait_ready

  task automatic ahb_rw(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rdv);
    @(posedge clk_in);
    ahb_m.hsel <= 1'b1;
    ahb_m.haddr <= {24'h00_0000, a};
    ahb_m.htrans <= 2'b10;
    ahb_m.hwrite <= wr;
    ahb_m.hsize <= 3'b010;
    wait_ready();
    ahb_m.hsel <= 1'b0;
    ahb_m.htrans <= 2'b00;
    ahb_m.hwdata <= wd;
    wait_ready();
    rdv = hrdata;
    check("hresp", hresp, 0);
  endtask : ahb_rw

  function automatic logic [31:0] cfgw(input int cwl, input int al, input logic dll,
                                       input logic [1:0] wr, input logic [2:0] nom);
    dtc_cfg_s c;
    c.al = al[4:0];
    c.cwl = cwl[3:0];
    c.dll_pd_on = dll;
    c.rtt_wr = wr;
    c.rtt_nom = nom;
    return {17'h0_0000, c};
  endfunction : cfgw

  // ==========================================================================
  // Scenarios.
  task automatic test_regs();
    ahb_rw(1'b0, CFG_OFS, 0, rd);
    check("cfg reset", rd, 32'h0000_0140);
    ahb_rw(1'b0, STAT_OFS, 0, rd);
    check("status reset", rd, 32'h0000_0000);
    ahb_rw(1'b1, CFG_OFS, 32'hFFFF_FFFF, rd);
    ahb_rw(1'b0, CFG_OFS, 0, rd);
    check("cfg bits", rd, 32'h0000_7FFF);
    ahb_rw(1'b1, STAT_OFS, 32'hFFFF_FFFF, rd);
    ahb_rw(1'b0, STAT_OFS, 0, rd);
    check("status ro", rd, 32'h0000_0000);
    ahb_rw(1'b0, 8'h08, 0, rd);
    check("unmapped", rd, 32'h0000_0000);
  endtask : test_regs

  task automatic test_latency();
    int tbl[4][3] = '{'{5, 0, 1}, '{6, 2, 5}, '{9, 4, 4}, '{5, 0, 0}};
    int lat;
    logic on;
    for (int i = 0; i < 4; i++) begin
      lat = tbl[i][0] + tbl[i][1] - 2;
      on = (tbl[i][2] != 0);
      ahb_rw(1'b1, CFG_OFS, cfgw(tbl[i][0], tbl[i][1], 1'b1, 2'b00, 3'(tbl[i][2])), rd);
      i_ctrl.set_odt(1'b1);
      step(lat - 1);
      check("on early", rtt_on, 0);
      step(1);
      check("on", rtt_on, on);
      check("nom val", rtt_val, tbl[i][2]);
      check("no wr sel", wr_sel, 0);
      i_ctrl.set_odt(1'b0);
      step(lat - 1);
      check("off early", rtt_on, on);
      step(1);
      check("off", rtt_on, 0);
    end
  endtask : test_latency

  task automatic test_dynamic();
    int n;
    i_ctrl.set_odt(1'b1);
    for (int w = 0; w < 4; w++) begin
      n = w[0] ? 4 : 6;
      ahb_rw(1'b1, CFG_OFS, cfgw(5, 0, 1'b1, 2'(w), 3'b001), rd);
      i_ctrl.pulse_cmd(1'b1, w[0]);
      step(2);
      check("cnw early", wr_sel, 0);
      step(1);
      check("cnw", wr_sel, w != 0);
      check("wr val", rtt_val, (w != 0) ? 32'(w) : 32'h1);
      step(n - 1);
      check("cwn late", wr_sel, w != 0);
      step(1);
      check("cwn", wr_sel, 0);
      check("back to nom", rtt_val, 1);
    end
    i_ctrl.pulse_cmd(1'b1, 1'b0);
    i_ctrl.pulse_cmd(1'b1, 1'b0);
    step(8);
    check("b2b hold", wr_sel, 1);
    step(1);
    check("b2b end", wr_sel, 0);
    i_ctrl.set_odt(1'b0);
    step(4);
  endtask : test_dynamic

  task automatic test_read();
    ahb_rw(1'b1, CFG_OFS, cfgw(5, 0, 1'b1, 2'b00, 3'b010), rd);
    i_ctrl.set_dq(1'b1);
    i_ctrl.set_odt(1'b1);
    step(5);
    check("off in read", rtt_on, 0);
    i_ctrl.set_dq(1'b0);
    step(2);
    check("on after read", rtt_on, 1);
    i_ctrl.set_odt(1'b0);
    step(4);
  endtask : test_read

  task automatic test_ce();
    ahb_rw(1'b1, CFG_OFS, cfgw(5, 0, 1'b1, 2'b00, 3'b001), rd);
    @(posedge clk_in);
    ce <= 1'b0;
    i_ctrl.set_odt(1'b1);
    step(6);
    check("frozen", rtt_on, 0);
    @(posedge clk_in);
    ce <= 1'b1;
    step(3);
    check("thaw early", rtt_on, 0);
    step(1);
    check("thaw on", rtt_on, 1);
    i_ctrl.set_odt(1'b0);
    step(4);
  endtask : test_ce

  task automatic test_pd(input logic refr);
    int n;
    ahb_rw(1'b1, CFG_OFS, cfgw(5, 4, 1'b0, 2'b00, 3'b001), rd);
    if (!refr) begin
      i_ctrl.set_idle(1'b0);
      i_ctrl.set_cke(1'b0);
      step(3);
      check("active pd", 32'({trans, async_m}), 32'h0000_0000);
      i_ctrl.set_cke(1'b1);
      i_ctrl.set_idle(1'b1);
    end
    if (refr) i_ctrl.pulse_cmd(1'b0, 1'b0);
    i_ctrl.set_cke(1'b0);
    #1;
    check("trans start", trans, 1);
    step(refr ? 30 : TCPDED_CYC);
    check("trans hold", trans, 1);
    check("sync in trans", async_m, 0);
    n = 0;
    while (async_m !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    if (!refr) check("entry cycles", 32'(n), 1);
    check("async", async_m, 1);
    check("trans end", trans, 0);
    i_ctrl.set_odt(1'b1);
    step(1);
    check("async on", rtt_on, 1);
    ahb_rw(1'b0, STAT_OFS, 0, rd);
    check("status pd", rd, 32'h0000_0015);
    i_ctrl.set_odt(1'b0);
    step(1);
    check("async off", rtt_on, 0);
    i_ctrl.set_cke(1'b1);
    #1;
    check("sync again", async_m, 0);
    step(4);
  endtask : test_pd

  // ==========================================================================
  // Clock, reset, sequence and watchdog.
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  initial begin
    resetn_in = 1'b0;
    ce = 1'b1;
    ahb_m = '0;
    fails = 0;
    compares = 0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    test_regs();
    test_latency();
    test_dynamic();
    test_read();
    test_ce();
    test_pd(1'b0);
    test_pd(1'b1);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    finish_test();
  end
endmodule : dtc_top_tb
